// ==== rtl/peci_bank_consts.vh ====
// Register indices, field positions, reset values and counts for the PECI agent bank
`ifndef PECI_BANK_CONSTS_VH
`define PECI_BANK_CONSTS_VH

// Register indices; byte address on APB is four times the index
`define IDX_AGENT_CFG      8'hE0
`define IDX_AGENT1_TREF    8'hE1
`define IDX_AGENT2_TREF    8'hE2
`define IDX_AGENT3_TREF    8'hE3
`define IDX_AGENT4_TREF    8'hE4
`define IDX_DOMAIN_CFG     8'hE5
`define IDX_AGENT4_REL_LO  8'hE6
`define IDX_AGENT4_REL_HI  8'hE7
`define IDX_WARN_FLAGS     8'hE8
`define IDX_INT_STATUS     8'hF8
`define IDX_INT_MASK       8'hF9

// Reset values
`define RST_AGENT_CFG      8'h00
`define RST_TREF           7'h48
`define RST_DOMAIN_CFG     8'h00
`define RST_WARN_FLAGS     8'h00
`define RST_INT            8'h00

// Field positions
`define FLD_ENABLE_LSB     4
`define FLD_RTD_LSB        0
`define FLD_D1_LSB         4
`define FLD_RET_HIGH       1
`define FLD_AGENT_FLAG_LSB 4
`define FLD_BANK_SEL       3
`define FLD_SPEED_LSB      0
`define FLD_INT_FCS_LSB    0
`define FLD_INT_ABSENT_LSB 4

// Speed select codes
`define SPEED_1M5          2'h0
`define SPEED_750K         2'h1
`define SPEED_375K         2'h2
`define SPEED_187K         2'h3

// PECI client address of agent 1; agents 2..4 follow
`define CLIENT_ADDR_BASE   8'h30
`define NUM_AGENTS         4

// Transactions kept in the FCS history
`define FCS_HISTORY        3

`endif

// ==== rtl/agent_result_track.v ====
// Per-agent store of reported temperature, FCS history and absent flag
`timescale 1ns/1ps
`default_nettype none

module agent_result_track #(
  parameter HIST = 3
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  input  wire        update,
  input  wire        fcs_bad,
  input  wire        absent,
  input  wire [15:0] dom0_temp,
  input  wire [15:0] dom1_temp,
  input  wire        ret_high,
  input  wire        d1_present,
  input  wire        rtd,
  output wire        alert,
  output reg         absent_q,
  output reg  [15:0] rel_temp_q
);

  reg  [HIST-1:0] fcs_hist_q;
  reg  [15:0]     temp_sel;

  // Highest of both domains, or the selected domain when one is present
  always @* begin
    if (ret_high) begin
      temp_sel = ($signed(dom1_temp) > $signed(dom0_temp)) ? dom1_temp : dom0_temp;
    end else if (d1_present && rtd) begin
      temp_sel = dom1_temp;
    end else begin
      temp_sel = dom0_temp;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fcs_hist_q <= {HIST{1'b0}};
      absent_q   <= 1'b0;
      rel_temp_q <= 16'h0000;
    end else if (clk_en && update) begin
      fcs_hist_q <= {fcs_hist_q[HIST-2:0], fcs_bad};
      absent_q   <= absent;
      if (!absent && !fcs_bad) begin
        rel_temp_q <= temp_sel;
      end
    end
  end

  // Alert while any of the last HIST transactions carried a bad FCS
  assign alert = |fcs_hist_q;

endmodule // agent_result_track

`default_nettype wire

// ==== rtl/peci_agent_config_status_bank.v ====
// APB register bank for PECI agent configuration, temperatures and warning flags
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "peci_bank_consts.vh"

module peci_agent_config_status_bank #(
  parameter ADDR_W = 12,
  parameter HIST   = `FCS_HISTORY
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              clk_en,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata_q,
  output reg               pready_q,
  output reg               pslverr_q,
  input  wire              txn_done,
  input  wire [7:0]        txn_client_addr,
  input  wire              txn_fcs_bad,
  input  wire              txn_absent,
  input  wire [15:0]       txn_dom0_temp,
  input  wire [15:0]       txn_dom1_temp,
  output reg  [3:0]        agent_enable_q,
  output reg  [1:0]        peci_speed_q,
  output reg               irq_q
);

  // ==========================================================================
  // Register state
  // ==========================================================================
  reg  [3:0]  rtd_q;
  reg  [27:0] tref_q;
  reg  [3:0]  d1_present_q;
  reg         ret_high_q;
  reg         bank_q;
  reg  [7:0]  int_stat_q;
  reg  [7:0]  int_mask_q;

  localparam [7:0] agent_cfg_rst = `RST_AGENT_CFG;

  wire [3:0]  alert;
  wire [3:0]  absent;
  wire [63:0] rel_temp;

  // ==========================================================================
  // Transaction decode
  // ==========================================================================
  wire [7:0] client_base = `CLIENT_ADDR_BASE;
  wire [7:0] agent_off   = txn_client_addr - client_base;
  wire       addr_hit    = (txn_client_addr[7:2] == client_base[7:2]);
  reg  [3:0] agent_upd;

  always @* begin
    agent_upd = 4'h0;
    if (txn_done && addr_hit) begin
      agent_upd[agent_off[1:0]] = agent_enable_q[agent_off[1:0]];
    end
  end

  genvar g;
  generate
    for (g = 0; g < `NUM_AGENTS; g = g + 1) begin : gen_agent
      agent_result_track #(
        .HIST (HIST)
      ) u_track (
        .pclk       (pclk),
        .presetn    (presetn),
        .clk_en     (clk_en),
        .update     (agent_upd[g]),
        .fcs_bad    (txn_fcs_bad),
        .absent     (txn_absent),
        .dom0_temp  (txn_dom0_temp),
        .dom1_temp  (txn_dom1_temp),
        .ret_high   (ret_high_q),
        .d1_present (d1_present_q[g]),
        .rtd        (rtd_q[g]),
        .alert      (alert[g]),
        .absent_q   (absent[g]),
        .rel_temp_q (rel_temp[16*g +: 16])
      );
    end
  endgenerate

  // ==========================================================================
  // APB decode
  // ==========================================================================
  wire [7:0]        reg_idx  = paddr[9:2];
  wire              in_range = (paddr[ADDR_W-1:10] == {(ADDR_W-10){1'b0}});
  wire              setup    = psel && !penable;
  wire              access   = psel && penable && pready_q;
  wire              wr_en    = access && pwrite && !pslverr_q;
  reg  [7:0]        cfg_byte;
  reg  [7:0]        temp_byte;
  reg  [7:0]        rd_byte;
  reg               mapped;

  // Bank 0 view: configuration registers, E6 and E7 read as zero
  always @* begin
    cfg_byte = 8'h00;
    case (reg_idx)
      `IDX_AGENT_CFG: begin
        cfg_byte = {agent_enable_q, rtd_q};
      end
      `IDX_AGENT1_TREF: begin
        cfg_byte = {1'b0, tref_q[6:0]};
      end
      `IDX_AGENT2_TREF: begin
        cfg_byte = {1'b0, tref_q[13:7]};
      end
      `IDX_AGENT3_TREF: begin
        cfg_byte = {1'b0, tref_q[20:14]};
      end
      `IDX_AGENT4_TREF: begin
        cfg_byte = {1'b0, tref_q[27:21]};
      end
      `IDX_DOMAIN_CFG: begin
        cfg_byte = {d1_present_q, 2'b00, ret_high_q, 1'b0};
      end
      default: begin
        cfg_byte = 8'h00;
      end
    endcase
  end

  // Bank 1 view: relative temperatures, low byte then high byte per agent
  always @* begin
    temp_byte = 8'h00;
    case (reg_idx)
      `IDX_AGENT_CFG: begin
        temp_byte = rel_temp[7:0];
      end
      `IDX_AGENT1_TREF: begin
        temp_byte = rel_temp[15:8];
      end
      `IDX_AGENT2_TREF: begin
        temp_byte = rel_temp[23:16];
      end
      `IDX_AGENT3_TREF: begin
        temp_byte = rel_temp[31:24];
      end
      `IDX_AGENT4_TREF: begin
        temp_byte = rel_temp[39:32];
      end
      `IDX_DOMAIN_CFG: begin
        temp_byte = rel_temp[47:40];
      end
      `IDX_AGENT4_REL_LO: begin
        temp_byte = rel_temp[55:48];
      end
      `IDX_AGENT4_REL_HI: begin
        temp_byte = rel_temp[63:56];
      end
      default: begin
        temp_byte = 8'h00;
      end
    endcase
  end

  // Read view of each index under the current bank
  always @* begin
    rd_byte = 8'h00;
    mapped  = in_range && (paddr[1:0] == 2'b00);
    case (reg_idx)
      `IDX_AGENT_CFG, `IDX_AGENT1_TREF, `IDX_AGENT2_TREF, `IDX_AGENT3_TREF,
      `IDX_AGENT4_TREF, `IDX_DOMAIN_CFG, `IDX_AGENT4_REL_LO, `IDX_AGENT4_REL_HI: begin
        rd_byte = bank_q ? temp_byte : cfg_byte;
      end
      `IDX_WARN_FLAGS: begin
        rd_byte = {(bank_q ? absent : alert), bank_q, 1'b0, peci_speed_q};
      end
      `IDX_INT_STATUS: begin
        rd_byte = int_stat_q;
      end
      `IDX_INT_MASK: begin
        rd_byte = int_mask_q;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // APB answer: no wait cycle, data and error captured in the setup cycle
  // ==========================================================================
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (clk_en) begin
      if (setup) begin
        pready_q  <= 1'b1;
        prdata_q  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        pslverr_q <= !mapped;
      end else if (access) begin
        pready_q  <= 1'b0;
        pslverr_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Write strobes; bank 1 turns E0..E7 into read-only temperature bytes
  // ==========================================================================
  wire cfg_wr   = wr_en && !bank_q;
  wire we_agent = cfg_wr && (reg_idx == `IDX_AGENT_CFG);
  wire we_tref1 = cfg_wr && (reg_idx == `IDX_AGENT1_TREF);
  wire we_tref2 = cfg_wr && (reg_idx == `IDX_AGENT2_TREF);
  wire we_tref3 = cfg_wr && (reg_idx == `IDX_AGENT3_TREF);
  wire we_tref4 = cfg_wr && (reg_idx == `IDX_AGENT4_TREF);
  wire we_dom   = cfg_wr && (reg_idx == `IDX_DOMAIN_CFG);
  wire we_warn  = wr_en && (reg_idx == `IDX_WARN_FLAGS);
  wire we_stat  = wr_en && (reg_idx == `IDX_INT_STATUS);
  wire we_mask  = wr_en && (reg_idx == `IDX_INT_MASK);

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      agent_enable_q <= agent_cfg_rst[`FLD_ENABLE_LSB +: 4];
      rtd_q          <= agent_cfg_rst[`FLD_RTD_LSB +: 4];
    end else if (clk_en && we_agent) begin
      agent_enable_q <= pwdata[`FLD_ENABLE_LSB +: 4];
      rtd_q          <= pwdata[`FLD_RTD_LSB +: 4];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tref_q <= {4{`RST_TREF}};
    end else if (clk_en) begin
      if (we_tref1) begin
        tref_q[6:0] <= pwdata[6:0];
      end
      if (we_tref2) begin
        tref_q[13:7] <= pwdata[6:0];
      end
      if (we_tref3) begin
        tref_q[20:14] <= pwdata[6:0];
      end
      if (we_tref4) begin
        tref_q[27:21] <= pwdata[6:0];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d1_present_q <= 4'h0;
      ret_high_q   <= 1'b0;
    end else if (clk_en && we_dom) begin
      d1_present_q <= pwdata[`FLD_D1_LSB +: 4];
      ret_high_q   <= pwdata[`FLD_RET_HIGH];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_q       <= 1'b0;
      peci_speed_q <= `SPEED_1M5;
    end else if (clk_en && we_warn) begin
      bank_q       <= pwdata[`FLD_BANK_SEL];
      peci_speed_q <= pwdata[`FLD_SPEED_LSB +: 2];
    end
  end

  // ==========================================================================
  // Interrupts: sticky events, write one to clear, set wins over clear
  // ==========================================================================
  wire [7:0] int_set = {agent_upd & {4{txn_absent}}, agent_upd & {4{txn_fcs_bad}}};
  wire [7:0] int_clr = we_stat ? pwdata[7:0] : 8'h00;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_q <= `RST_INT;
      int_mask_q <= `RST_INT;
      irq_q      <= 1'b0;
    end else if (clk_en) begin
      int_stat_q <= (int_stat_q & ~int_clr) | int_set;
      irq_q      <= |(((int_stat_q & ~int_clr) | int_set) & int_mask_q);
      if (we_mask) begin
        int_mask_q <= pwdata[7:0];
      end
    end
  end

endmodule // peci_agent_config_status_bank

`default_nettype wire

// ==== bench/peci_client_model.sv ====
// Behavioural PECI engine standing in for the client agents on the wire
`timescale 1ns/1ps
`default_nettype none
module peci_client_model (
  input  wire logic        pclk,
  output var  logic        txn_done,
  output var  logic [7:0]  txn_client_addr,
  output var  logic        txn_fcs_bad,
  output var  logic        txn_absent,
  output var  logic [15:0] txn_dom0_temp,
  output var  logic [15:0] txn_dom1_temp
);
  initial begin
    txn_done = 1'b0;
    {txn_client_addr, txn_fcs_bad, txn_absent} = 10'h155;
    {txn_dom0_temp, txn_dom1_temp} = 32'hA5A5_5A5A;
  end
  // ============================================================
  // One finished transaction; a gap makes the answer slow
  task automatic send(input logic [7:0] a, input logic bad, gone,
                      input logic [15:0] d0, d1, input int gap);
    repeat (gap) @(posedge pclk);
    @(posedge pclk);
    txn_done <= 1'b1;
    {txn_client_addr, txn_fcs_bad, txn_absent} <= {a, bad, gone};
    {txn_dom0_temp, txn_dom1_temp} <= {d0, d1};
    @(posedge pclk);
    txn_done <= 1'b0;
    // Fields are not held once the pulse is over
    {txn_client_addr, txn_fcs_bad, txn_absent} <= ~{a, bad, gone};
    {txn_dom0_temp, txn_dom1_temp} <= ~{d0, d1};
  endtask
endmodule // peci_client_model
`default_nettype wire

// ==== bench/bank_checker_sva.sv ====
// Port assertions for the PECI agent register bank
`timescale 1ns/1ps
`default_nettype none
module bank_checker #(parameter ADDR_W = 12) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              clk_en,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata_q,
  input wire logic              pready_q,
  input wire logic              pslverr_q,
  input wire logic              txn_done,
  input wire logic [1:0]        peci_speed_q,
  input wire logic              irq_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire setup = psel && !penable && clk_en;
  wire acc_w = psel && penable && pwrite && pready_q && clk_en;
  // ============================================================
  // APB handshake
  ready_pulse_a: assert property (pready_q && clk_en |=> !pready_q) else $error("ready held");
  ready_follows_a: assert property (setup |=> pready_q) else $error("no ready");
  ready_cause_a: assert property (pready_q |-> $past(setup)) else $error("stray ready");
  err_ready_a: assert property (pslverr_q |-> pready_q) else $error("lone error");
  upper_zero_a: assert property (pready_q |-> prdata_q[31:8] == 24'h0) else $error("upper");
  misalign_err_a: assert property (setup && paddr[1:0] != 2'h0 |=> pslverr_q)
    else $error("misaligned accepted");
  // ============================================================
  // Speed select and interrupt
  speed_write_a: assert property (acc_w && paddr == 12'h3A0 |=>
    peci_speed_q == $past(pwdata[1:0])) else $error("speed write");
  speed_hold_a: assert property (!acc_w |=> $stable(peci_speed_q))
    else $error("speed moved");
  irq_cause_a: assert property ($rose(irq_q) |->
    $past(txn_done) || $past(acc_w, 2)) else $error("irq cause");
  cover property (pready_q && pslverr_q);
  cover property ($rose(irq_q));
  cover property (acc_w && paddr == 12'h3A0);
endmodule // bank_checker
bind peci_agent_config_status_bank bank_checker #(.ADDR_W(ADDR_W)) chk_i (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
  .pready_q(pready_q), .pslverr_q(pslverr_q), .txn_done(txn_done),
  .peci_speed_q(peci_speed_q), .irq_q(irq_q));
`default_nettype wire

// ==== bench/peci_agent_config_status_bank_bench.sv ====
// Self-checking bench for the PECI agent register bank
`timescale 1ns/1ps
`default_nettype none
module peci_agent_config_status_bank_bench;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready_q, pslverr_q;
  logic        txn_done, txn_fcs_bad, txn_absent, irq_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_q, r;
  logic [7:0]  txn_client_addr;
  logic [15:0] txn_dom0_temp, txn_dom1_temp;
  logic [3:0]  agent_enable_q;
  logic [1:0]  peci_speed_q;
  logic        e;
  int          num_errors = 0;
  int          compares = 0;
  // Row: write flag, address, write data, expected read, expected error
  logic [29:0] rows [10] = '{
    {1'b0, 12'h38C, 8'h00, 8'h48, 1'b0}, {1'b0, 12'h390, 8'h00, 8'h48, 1'b0},
    {1'b0, 12'h394, 8'h00, 8'h00, 1'b0}, {1'b0, 12'h3A0, 8'h00, 8'h00, 1'b0},
    {1'b1, 12'h38C, 8'hFF, 8'h7F, 1'b0}, {1'b1, 12'h390, 8'hC5, 8'h45, 1'b0},
    {1'b1, 12'h394, 8'hFF, 8'hF2, 1'b0}, {1'b1, 12'h398, 8'h55, 8'h00, 1'b0},
    {1'b0, 12'h3C0, 8'h00, 8'h00, 1'b1}, {1'b0, 12'h381, 8'h00, 8'h00, 1'b1}};
  peci_agent_config_status_bank uut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
    .pready_q(pready_q), .pslverr_q(pslverr_q), .txn_done(txn_done),
    .txn_client_addr(txn_client_addr), .txn_fcs_bad(txn_fcs_bad),
    .txn_absent(txn_absent), .txn_dom0_temp(txn_dom0_temp),
    .txn_dom1_temp(txn_dom1_temp), .agent_enable_q(agent_enable_q),
    .peci_speed_q(peci_speed_q), .irq_q(irq_q));
  peci_client_model pm (
    .pclk(pclk), .txn_done(txn_done), .txn_client_addr(txn_client_addr),
    .txn_fcs_bad(txn_fcs_bad), .txn_absent(txn_absent),
    .txn_dom0_temp(txn_dom0_temp), .txn_dom1_temp(txn_dom1_temp));
  // ============================================================
  // Tasks
  task automatic chk(input logic [31:0] g, x);
    compares++;
    if (g !== x) begin
      num_errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready_q !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    r = prdata_q;
    e = pslverr_q;
    {psel, penable} <= 2'b00;
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk(r, {24'h0, x});
    chk({31'h0, e}, 32'h0);
  endtask
  task automatic wrap_up;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    wrap_up;
  end
  // ============================================================
  // Main sequence
  initial begin
    {presetn, clk_en, psel, penable, pwrite, paddr, pwdata} = {2'b01, 47'h0};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk({26'h0, agent_enable_q, peci_speed_q}, 32'h0);
    for (int i = 0; i < 10; i++) begin
      if (rows[i][29]) wr(rows[i][28:17], rows[i][16:9]);
      apb(1'b0, rows[i][28:17], 8'h00);
      chk(r, {24'h0, rows[i][8:1]});
      chk({31'h0, e}, {31'h0, rows[i][0]});
    end
    for (int s = 0; s < 4; s++) begin
      wr(12'h3A0, 8'(s));
      chk({30'h0, peci_speed_q}, 32'(s));
    end
    wr(12'h3A0, 8'h00);
    wr(12'h380, 8'hF0);
    wr(12'h3E4, 8'hFF);
    pm.send(8'h32, 1'b0, 1'b0, 16'h0005, 16'hFFF0, 0);
    pm.send(8'h33, 1'b0, 1'b0, 16'h0010, 16'h0120, 3);
    wr(12'h3A0, 8'h08);
    rd(12'h390, 8'h05);
    rd(12'h394, 8'h00);
    rd(12'h398, 8'h20);
    rd(12'h39C, 8'h01);
    wr(12'h398, 8'hAA);
    rd(12'h398, 8'h20);
    rd(12'h3A0, 8'h08);
    wr(12'h3A0, 8'h00);
    wr(12'h394, 8'h10);
    wr(12'h380, 8'hF3);
    pm.send(8'h30, 1'b0, 1'b0, 16'h0101, 16'h0202, 0);
    pm.send(8'h31, 1'b0, 1'b0, 16'h0303, 16'h0404, 0);
    wr(12'h3A0, 8'h08);
    rd(12'h380, 8'h02);
    rd(12'h384, 8'h02);
    rd(12'h388, 8'h03);
    rd(12'h38C, 8'h03);
    wr(12'h380, 8'h00);
    chk({28'h0, agent_enable_q}, 32'hF);
    wr(12'h3A0, 8'h00);
    pm.send(8'h33, 1'b1, 1'b0, 16'h0, 16'h0, 0);
    rd(12'h3A0, 8'h80);
    chk({31'h0, irq_q}, 32'h1);
    rd(12'h3E0, 8'h08);
    pm.send(8'h33, 1'b0, 1'b0, 16'h0, 16'h0, 0);
    pm.send(8'h33, 1'b0, 1'b0, 16'h0, 16'h0, 1);
    rd(12'h3A0, 8'h80);
    pm.send(8'h33, 1'b0, 1'b0, 16'h0, 16'h0, 0);
    rd(12'h3A0, 8'h00);
    wr(12'h3E0, 8'h08);
    rd(12'h3E0, 8'h00);
    chk({31'h0, irq_q}, 32'h0);
    wr(12'h3E4, 8'h00);
    pm.send(8'h30, 1'b1, 1'b0, 16'h0, 16'h0, 0);
    rd(12'h3E0, 8'h01);
    chk({31'h0, irq_q}, 32'h0);
    wr(12'h3E4, 8'h01);
    rd(12'h3E0, 8'h01);
    chk({31'h0, irq_q}, 32'h1);
    wr(12'h3E0, 8'h01);
    pm.send(8'h31, 1'b0, 1'b1, 16'h0, 16'h0, 0);
    wr(12'h3A0, 8'h08);
    rd(12'h3A0, 8'h28);
    wr(12'h3A0, 8'h00);
    wr(12'h380, 8'h70);
    wr(12'h3E0, 8'hFF);
    pm.send(8'h33, 1'b1, 1'b0, 16'h0, 16'h0, 0);
    pm.send(8'h34, 1'b1, 1'b0, 16'h0, 16'h0, 0);
    rd(12'h3E0, 8'h00);
    rd(12'h3A0, 8'h10);
    // Clock enable low: a finished transaction leaves no trace
    @(posedge pclk);
    clk_en <= 1'b0;
    pm.send(8'h31, 1'b1, 1'b1, 16'h0, 16'h0, 0);
    clk_en <= 1'b1;
    rd(12'h3E0, 8'h00);
    rd(12'h3A0, 8'h10);
    // Raise the interrupt, then reset in mid-run
    pm.send(8'h30, 1'b1, 1'b0, 16'h0, 16'h0, 0);
    #1;
    chk({31'h0, irq_q}, 32'h1);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk({26'h0, agent_enable_q, peci_speed_q}, 32'h0);
    chk({31'h0, irq_q}, 32'h0);
    rd(12'h38C, 8'h48);
    rd(12'h3A0, 8'h00);
    rd(12'h3E0, 8'h00);
    wrap_up;
  end
endmodule // peci_agent_config_status_bank_bench
`default_nettype wire
